// File: hdl/ldc_led_drive_config.sv
`default_nettype none

// Operation
// R1: first driver slew code in control bits 6:4, 0 slowest, 7 fastest.
// R2: second driver slew code in its control bits 6:4, same ordering.
// R3: first driver 4-bit coarse code in bits 3:0, linear current steps.
// R4: second driver 4-bit coarse code in its bits 3:0, same mapping.
// R5: coarse, fine and strength reach each driver together as one set.
// R6: second driver bit 13 selects full strength, zero means low power.
// R7: third driver 5-bit fine trim in trim bits 15:11.
// R8: second driver 5-bit fine trim in trim bits 10:6, reset 0xC.
// R9: first driver fine trim in bits 4:0, reset 0xC; bit 5 reserved.
// R10: first driver bit 13 selects full strength, zero means low power.
// R11: software writes reserved bits with their stated values.
// R12: fields reset to defaults and read back exactly what was written.
module ldc_led_drive_config
    import ldc_pkg::*;
(
    input  wire logic        clk,                           // register clock
    input  wire logic        rst_b,                         // async reset, active low
    input  wire logic        reg_wr_en,                     // write strobe from serial port engine
    input  wire logic        reg_rd_en,                     // read strobe from serial port engine
    input  wire logic [7:0]  reg_addr,                      // register index
    input  wire logic [15:0] reg_wr_data,                   // write data
    output logic      [15:0] reg_rd_data,                   // read data, held until next read
    output logic             reg_rd_valid,                  // one-cycle read answer pulse
    output logic             reg_addr_miss,                 // one-cycle pulse, access to other index
    output logic             reserved_write_seen,           // sticky, reserved bits written wrongly
    input  wire logic        reserved_seen_clr,             // clears reserved_write_seen
    output logic      [2:0]  first_driver_slew_code,        // first driver slew
    output logic      [3:0]  first_driver_coarse_code,      // first driver coarse
    output logic      [4:0]  first_driver_fine_trim,        // first driver fine
    output logic             first_driver_strength_select,  // first driver strength
    output logic      [2:0]  second_driver_slew_code,       // second driver slew
    output logic      [3:0]  second_driver_coarse_code,     // second driver coarse
    output logic      [4:0]  second_driver_fine_trim,       // second driver fine
    output logic             second_driver_strength_select, // second driver strength
    output logic      [4:0]  third_driver_fine_trim         // third driver fine
);

    ldc_state_t state_ff;
    ldc_state_t nxt_state;

    logic       hit_a;
    logic       hit_b;
    logic       hit_trim;
    logic       hit_any;
    logic       bad_rsvd;

    always_comb
    begin
        hit_a    = (reg_addr == LDC_ADDR_LED_A_DRIVE_CONTROL);
        hit_b    = (reg_addr == LDC_ADDR_LED_B_DRIVE_CONTROL);
        hit_trim = (reg_addr == LDC_ADDR_LED_FINE_TRIM);
        hit_any  = hit_a | hit_b | hit_trim;
        bad_rsvd = 1'b0;
        nxt_state = state_ff;

        // whole words are stored, reserved bits included, so readback is exact
        if (reg_wr_en && hit_a)
        begin
            nxt_state.ctl_a = reg_wr_data;  // see R1, see R3, see R10, see R12
            bad_rsvd = !ldc_ctl_rsvd_ok(reg_wr_data);  // see R11
        end
        if (reg_wr_en && hit_b)
        begin
            nxt_state.ctl_b = reg_wr_data;  // see R2, see R4, see R6, see R12
            bad_rsvd = !ldc_ctl_rsvd_ok(reg_wr_data);  // see R11
        end
        if (reg_wr_en && hit_trim)
        begin
            nxt_state.trim = reg_wr_data;  // see R7, see R8, see R9, see R12
            bad_rsvd = !ldc_trim_rsvd_ok(reg_wr_data);  // see R11
        end

        // read sees the value before a same-cycle write; no side effects
        nxt_state.rd_valid = reg_rd_en;
        if (reg_rd_en)
        begin
            if (hit_a)
            begin
                nxt_state.rd_data = state_ff.ctl_a;  // see R12
            end
            else if (hit_b)
            begin
                nxt_state.rd_data = state_ff.ctl_b;  // see R12
            end
            else if (hit_trim)
            begin
                nxt_state.rd_data = state_ff.trim;  // see R12
            end
            else
            begin
                nxt_state.rd_data = LDC_RST_RD_DATA;
            end
        end
        nxt_state.addr_miss = (reg_rd_en | reg_wr_en) & !hit_any;

        // set wins over clear so a violation in the clearing cycle is kept
        if (bad_rsvd)
        begin
            nxt_state.rsvd_seen = 1'b1;
        end
        else if (reserved_seen_clr)
        begin
            nxt_state.rsvd_seen = 1'b0;
        end

        // extra stage keeps the third driver in step with the other two bundles
        nxt_state.third_fine = ldc_fine_of(state_ff.trim, LDC_TRIM_THIRD_LSB);  // see R7
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= '{ctl_a: LDC_RST_DRIVE_CONTROL, ctl_b: LDC_RST_DRIVE_CONTROL,
                          trim: LDC_RST_FINE_TRIM, rd_data: LDC_RST_RD_DATA,
                          rd_valid: 1'b0, addr_miss: 1'b0, rsvd_seen: 1'b0,
                          third_fine: LDC_RST_FINE};  // see R12
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign reg_rd_data           = state_ff.rd_data;
    assign reg_rd_valid          = state_ff.rd_valid;
    assign reg_addr_miss         = state_ff.addr_miss;
    assign reserved_write_seen   = state_ff.rsvd_seen;
    assign third_driver_fine_trim = state_ff.third_fine;

    // see R5: each driver gets its fields from one register stage
    ldc_drive_bundle u_first_led_driver
    (
        .clk          (clk),
        .rst_b        (rst_b),
        .ctl_word     (state_ff.ctl_a),
        .fine_code    (ldc_fine_of(state_ff.trim, LDC_TRIM_FIRST_LSB)),  // see R9
        .slew_code    (first_driver_slew_code),
        .coarse_code  (first_driver_coarse_code),
        .fine_trim    (first_driver_fine_trim),
        .strength_sel (first_driver_strength_select)
    );

    ldc_drive_bundle u_second_led_driver
    (
        .clk          (clk),
        .rst_b        (rst_b),
        .ctl_word     (state_ff.ctl_b),
        .fine_code    (ldc_fine_of(state_ff.trim, LDC_TRIM_SECOND_LSB)),  // see R8
        .slew_code    (second_driver_slew_code),
        .coarse_code  (second_driver_coarse_code),
        .fine_trim    (second_driver_fine_trim),
        .strength_sel (second_driver_strength_select)
    );

endmodule : ldc_led_drive_config

`default_nettype wire

// File: hdl/ldc_pkg.sv
`default_nettype none

package ldc_pkg;

    // register indices on the device's internal register port
    localparam logic [7:0]  LDC_ADDR_LED_A_DRIVE_CONTROL = 8'h23;
    localparam logic [7:0]  LDC_ADDR_LED_B_DRIVE_CONTROL = 8'h24;
    localparam logic [7:0]  LDC_ADDR_LED_FINE_TRIM       = 8'h25;

    // reset values: strength bit 13 and reserved bit 12 come up set,
    // every fine-trim field comes up at 0xC
    localparam logic [15:0] LDC_RST_DRIVE_CONTROL        = 16'h3000;
    localparam logic [15:0] LDC_RST_FINE_TRIM            = 16'h630C;
    localparam logic [15:0] LDC_RST_RD_DATA              = 16'h0000;

    // drive control field positions
    localparam int          LDC_CTL_STRENGTH_BIT         = 13;
    localparam int          LDC_CTL_SLEW_LSB             = 4;
    localparam int          LDC_CTL_COARSE_LSB           = 0;
    localparam logic [15:0] LDC_CTL_RSVD_ZERO_MASK       = 16'hCF80;
    localparam logic [15:0] LDC_CTL_RSVD_ONE_MASK        = 16'h1000;

    // fine trim field positions
    localparam int          LDC_TRIM_THIRD_LSB           = 11;
    localparam int          LDC_TRIM_SECOND_LSB          = 6;
    localparam int          LDC_TRIM_FIRST_LSB           = 0;
    localparam logic [15:0] LDC_TRIM_RSVD_ZERO_MASK      = 16'h0020;

    // per-driver reset values seen at the driver pins
    localparam logic [2:0]  LDC_RST_SLEW                 = 3'h0;
    localparam logic [3:0]  LDC_RST_COARSE               = 4'h0;
    localparam logic [4:0]  LDC_RST_FINE                 = 5'h0C;
    localparam logic        LDC_RST_STRENGTH             = 1'b1;

    typedef struct packed {
        logic [15:0] ctl_a;
        logic [15:0] ctl_b;
        logic [15:0] trim;
        logic [15:0] rd_data;
        logic        rd_valid;
        logic        addr_miss;
        logic        rsvd_seen;
        logic [4:0]  third_fine;
    } ldc_state_t;

    typedef struct packed {
        logic [2:0] slew;
        logic [3:0] coarse;
        logic [4:0] fine;
        logic       strength;
    } ldc_drive_t;

    function automatic logic [2:0] ldc_slew_of(input logic [15:0] word);
        ldc_slew_of = word[LDC_CTL_SLEW_LSB +: 3];
    endfunction : ldc_slew_of

    function automatic logic [3:0] ldc_coarse_of(input logic [15:0] word);
        ldc_coarse_of = word[LDC_CTL_COARSE_LSB +: 4];
    endfunction : ldc_coarse_of

    function automatic logic ldc_strength_of(input logic [15:0] word);
        ldc_strength_of = word[LDC_CTL_STRENGTH_BIT];
    endfunction : ldc_strength_of

    function automatic logic [4:0] ldc_fine_of(input logic [15:0] word, input int lsb);
        ldc_fine_of = word[lsb +: 5];
    endfunction : ldc_fine_of

    function automatic logic ldc_ctl_rsvd_ok(input logic [15:0] word);
        ldc_ctl_rsvd_ok = ((word & LDC_CTL_RSVD_ZERO_MASK) == 16'h0000)
                          && ((word & LDC_CTL_RSVD_ONE_MASK) == LDC_CTL_RSVD_ONE_MASK);
    endfunction : ldc_ctl_rsvd_ok

    function automatic logic ldc_trim_rsvd_ok(input logic [15:0] word);
        ldc_trim_rsvd_ok = ((word & LDC_TRIM_RSVD_ZERO_MASK) == 16'h0000);
    endfunction : ldc_trim_rsvd_ok

endpackage : ldc_pkg

`default_nettype wire

// File: hdl/ldc_drive_bundle.sv
`default_nettype none

// registers one driver's slew, coarse, fine and strength in the same edge so the
// analog side never sees a half-updated peak current target
module ldc_drive_bundle
    import ldc_pkg::*;
(
    input  wire logic        clk,          // register clock
    input  wire logic        rst_b,        // async reset, active low
    input  wire logic [15:0] ctl_word,     // stored drive control word
    input  wire logic [4:0]  fine_code,    // stored fine-trim code
    output logic      [2:0]  slew_code,    // slew code to driver
    output logic      [3:0]  coarse_code,  // coarse code to driver
    output logic      [4:0]  fine_trim,    // fine multiplier code to driver
    output logic             strength_sel  // 1 full strength, 0 low power
);

    ldc_drive_t state_ff;
    ldc_drive_t nxt_state;

    always_comb
    begin
        nxt_state          = state_ff;
        nxt_state.slew     = ldc_slew_of(ctl_word);
        nxt_state.coarse   = ldc_coarse_of(ctl_word);
        nxt_state.fine     = fine_code;
        nxt_state.strength = ldc_strength_of(ctl_word);
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_ff <= '{slew: LDC_RST_SLEW, coarse: LDC_RST_COARSE,
                          fine: LDC_RST_FINE, strength: LDC_RST_STRENGTH};
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign slew_code    = state_ff.slew;
    assign coarse_code  = state_ff.coarse;
    assign fine_trim    = state_ff.fine;
    assign strength_sel = state_ff.strength;

endmodule : ldc_drive_bundle

`default_nettype wire

// File: test/ldc_sva.sv
`default_nettype none
module ldc_sva (
    input wire logic        clk,                           // clock
    input wire logic        rst_b,                         // reset
    input wire logic        reg_wr_en,                     // wr
    input wire logic        reg_rd_en,                     // rd
    input wire logic [7:0]  reg_addr,                      // index
    input wire logic [15:0] reg_wr_data,                   // data
    input wire logic        reg_rd_valid,                  // answer
    input wire logic        reg_addr_miss,                 // miss
    input wire logic [2:0]  first_driver_slew_code,        // a slew
    input wire logic [3:0]  first_driver_coarse_code,      // a coarse
    input wire logic [4:0]  first_driver_fine_trim,        // a fine
    input wire logic        first_driver_strength_select,  // a strength
    input wire logic [2:0]  second_driver_slew_code,       // b slew
    input wire logic [3:0]  second_driver_coarse_code,     // b coarse
    input wire logic [4:0]  second_driver_fine_trim,       // b fine
    input wire logic        second_driver_strength_select, // b strength
    input wire logic [4:0]  third_driver_fine_trim         // c fine
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_wr_a; reg_wr_en && reg_addr == 8'h23; endsequence
    sequence s_wr_b; reg_wr_en && reg_addr == 8'h24; endsequence
    sequence s_wr_t; reg_wr_en && reg_addr == 8'h25; endsequence
    a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read not answered");
    a_addr_miss: assert property ((reg_wr_en || reg_rd_en) && !(reg_addr inside {[8'h23:8'h25]}) |=> reg_addr_miss)
        else $error("miss not flagged");
    a_first_slew: assert property (s_wr_a |=> ##1 first_driver_slew_code == $past(reg_wr_data[6:4], 2))
        else $error("first slew wrong");
    a_first_coarse: assert property (s_wr_a |=> ##1 first_driver_coarse_code == $past(reg_wr_data[3:0], 2))
        else $error("first coarse wrong");
    a_first_strength: assert property (s_wr_a |=> ##1 first_driver_strength_select == $past(reg_wr_data[13], 2))
        else $error("first strength wrong");
    a_second_ctl: assert property (s_wr_b |=> ##1 {second_driver_slew_code, second_driver_coarse_code,
        second_driver_strength_select} == $past({reg_wr_data[6:0], reg_wr_data[13]}, 2)) else $error("second ctl wrong");
    a_fine_trim: assert property (s_wr_t |=> ##1 {third_driver_fine_trim, second_driver_fine_trim,
        first_driver_fine_trim} == $past({reg_wr_data[15:6], reg_wr_data[4:0]}, 2)) else $error("fine trim wrong");
    a_fine_cause: assert property ($changed(first_driver_fine_trim) |-> $past(reg_wr_en && reg_addr == 8'h25, 2))
        else $error("fine changed without write");
endmodule : ldc_sva
`default_nettype wire

// File: test/testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst_b, reg_wr_en, reg_rd_en, reserved_seen_clr, reg_rd_valid, reg_addr_miss, reserved_write_seen;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wr_data, reg_rd_data, w_a, w_b, w_t;
    logic [2:0]  first_driver_slew_code, second_driver_slew_code;
    logic [3:0]  first_driver_coarse_code, second_driver_coarse_code;
    logic [4:0]  first_driver_fine_trim, second_driver_fine_trim, third_driver_fine_trim;
    logic        first_driver_strength_select, second_driver_strength_select;
    logic [16:0] exp_q[$];
    int          n_mismatch = 0;
    int          n_compared = 0;
    integer      seed = 32'h1185EF42;
    ldc_led_drive_config i_dut (.clk, .rst_b, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data, .reg_rd_data,
        .reg_rd_valid, .reg_addr_miss, .reserved_write_seen, .reserved_seen_clr, .first_driver_slew_code,
        .first_driver_coarse_code, .first_driver_fine_trim, .first_driver_strength_select, .second_driver_slew_code,
        .second_driver_coarse_code, .second_driver_fine_trim, .second_driver_strength_select, .third_driver_fine_trim);
    always #50 clk = ~clk;
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task cyc(input logic wr, input logic rd, input logic [7:0] addr, input logic [15:0] data);
        @(posedge clk);
        reg_wr_en <= wr;
        reg_rd_en <= rd;
        reg_addr <= addr;
        reg_wr_data <= data;
    endtask : cyc
    // expected read word is queued before the strobe so the monitor always finds it
    task rd(input logic [7:0] addr, input logic [16:0] exp);
        exp_q.push_back(exp);
        cyc(1'b0, 1'b1, addr, 16'h0000);
    endtask : rd
    task check_all;
        rd(8'h23, {1'b0, w_a});
        rd(8'h24, {1'b0, w_b});
        rd(8'h25, {1'b0, w_t});
        rd(8'h26, 17'h10000);
        repeat (4) cyc(1'b0, 1'b0, 8'h00, 16'h0000);
        #1;
        chk({1'b0, first_driver_slew_code, first_driver_coarse_code, first_driver_fine_trim,
            first_driver_strength_select, second_driver_slew_code, second_driver_coarse_code, second_driver_fine_trim,
            second_driver_strength_select, third_driver_fine_trim}, {1'b0, w_a[6:0], w_t[4:0], w_a[13],
            w_b[6:0], w_t[10:6], w_b[13], w_t[15:11]});
        chk(32'(exp_q.size()), 32'h0);
    endtask : check_all
    task do_reset;
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        w_a = 16'h3000;
        w_b = 16'h3000;
        w_t = 16'h630C;
        check_all;
        chk({31'h0, reserved_write_seen}, 32'h0);
    endtask : do_reset
    task finish_test;
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : finish_test
    always @(posedge clk)
    begin
        if (reg_rd_valid === 1'b1)
            chk({15'h0000, reg_addr_miss, reg_rd_data}, {15'h0000, exp_q.pop_front()});
    end
    initial
    begin
        rst_b = 1'b0;
        {reg_wr_en, reg_rd_en, reserved_seen_clr, reg_addr, reg_wr_data} = '0;
        do_reset;
        for (int i = 0; i < 16; i++)
        begin
            w_a = {2'b00, i[0], 1'b1, 5'h00, i[2:0], i[3:0]};
            w_b = 16'h1000 | (16'($random(seed)) & 16'h207F);
            w_t = 16'($random(seed)) & 16'hFFDF;
            cyc(1'b1, 1'b0, 8'h23, w_a);
            cyc(1'b1, 1'b0, 8'h24, w_b);
            cyc(1'b1, 1'b0, 8'h25, w_t);
            // unmapped index: must be dropped, check_all proves nothing moved
            cyc(1'b1, 1'b0, 8'h22, 16'hFFFF);
            check_all;
        end
        // same-edge read and write must return the word stored before the write
        exp_q.push_back({1'b0, w_a});
        cyc(1'b1, 1'b1, 8'h23, 16'h1000);
        w_a = 16'h1000;
        cyc(1'b1, 1'b0, 8'h25, 16'h0020);
        w_t = 16'h0020;
        cyc(1'b0, 1'b0, 8'h00, 16'h0000);
        #1 chk({31'h0, reserved_write_seen}, 32'h1);
        @(posedge clk) reserved_seen_clr <= 1'b1;
        @(posedge clk) reserved_seen_clr <= 1'b0;
        @(posedge clk) #1 chk({31'h0, reserved_write_seen}, 32'h0);
        // violation and clear in one cycle: the set must win
        cyc(1'b1, 1'b0, 8'h24, 16'h0000);
        reserved_seen_clr <= 1'b1;
        cyc(1'b0, 1'b0, 8'h00, 16'h0000);
        reserved_seen_clr <= 1'b0;
        #1 chk({31'h0, reserved_write_seen}, 32'h1);
        w_b = 16'h0000;
        check_all;
        do_reset;
        finish_test;
    end
    initial
    begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        finish_test;
    end
endmodule : testbench
bind ldc_led_drive_config ldc_sva i_sva (.clk, .rst_b, .reg_wr_en, .reg_rd_en, .reg_addr, .reg_wr_data,
    .reg_rd_valid, .reg_addr_miss, .first_driver_slew_code, .first_driver_coarse_code, .first_driver_fine_trim,
    .first_driver_strength_select, .second_driver_slew_code, .second_driver_coarse_code, .second_driver_fine_trim,
    .second_driver_strength_select, .third_driver_fine_trim);
`default_nettype wire
